/* File: acc_det_ctrl.sv */
// Accessory detection, switch routing and register file top
`timescale 1ns/1ns
// Function
// R1 - Any reset loads register defaults and opens all data switches.
// R2 - After reset the detector sits in standby watching bus power and ID.
// R3 - First rising edge of battery or bus power triggers power-on reset.
// R4 - Writing the reset bit at 0x1B resets like the hardware reset. Here the serial slave and the link handshake are not reset by it.
// R5 - Fast-mode serial slave carries all status reads and configuration writes.
// R6 - Interrupts stay suppressed until the mask bit at 0x02 is cleared.
// R7 - Control selects auto or manual routing; manual uses register 0x13.
// R8 - Default charging picks low or high current by accessory type.
// R9 - Monitor bus power and ID pin; classify from ID resistance.
// R10 - Report the 5-bit code and interrupt, unknown codes included.
// R11 - In-between resistances give a neighbour code; open ID gives all ones.
// R12 - Charger ID codes are recognised only while bus power is valid.
// R13 - Code near 255k is factory cable, boot off, USB route.
// R14 - Code near 301k is factory cable, boot on, USB route.
// R15 - Codes near 523k and 619k are UART factory cables, boot off/on.
// R16 - Factory cables auto-connect: UART to alternate pair, USB to USB pair.
// R17 - Changing between factory codes reroutes immediately without reattach.
// R18 - On a detection change update status first, then assert interrupt.
// R19 - Bus power, open ID and shorted data lines means dedicated charger.
// R20 - Bus power and open ID split charging from standard downstream port.
// R21 - Downstream ports route to USB host; dedicated charger leaves switches open.
// R22 - Interrupt pin goes low on change; register 0x03 tells attach or detach.
// R23 - Every serial register is eight bits, byte-wide reads and writes.
module acc_det_ctrl import acc_det_pkg::*; #(
  parameter logic [6:0] SLAVE_ADDR = SLAVE_ADDR_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic adc_clk,
  input wire logic adc_sample,
  input wire sense_t adc_sense,
  input wire logic bus_power_in,
  input wire logic bat_power_ok,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic attach_irq_n,
  output switch_t sw_route,
  output logic charge_high_current
);
  logic [1:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_f_q;
  logic vbus_ok, supply_prev_q, por_done_q, por_q, soft_q, int_rst;
  logic [5:0] rst_cnt_q;
  logic rst_hold_q;
  logic [1:0] arst_q;
  logic [2:0] ack_sy_q, req_sy_q;
  logic ack_f_q, req_q, req_f_q, samp_q, change;
  sense_t hold_q, sense_q;
  acc_t cls, acc_q;
  logic [4:0] code_q;
  det_state_t state_q;
  logic [7:0] ctrl_q, man_q, rd_data, reg_addr, wr_data;
  logic wr_en, rd_en;
  logic [1:0] int_q, int_set;
  switch_t route_q;

  // Supply pins: three stages, a change counts once stages two and three agree
  always_ff @(posedge ref_clk) begin
    pin_s1_q <= {bat_power_ok, bus_power_in};
    pin_s2_q <= pin_s1_q;
    pin_s3_q <= pin_s2_q;
    if (rst) begin
      pin_f_q <= 2'b00;
    end else begin
      pin_f_q <= (pin_s3_q & ~(pin_s2_q ^ pin_s3_q)) | (pin_f_q & (pin_s2_q ^ pin_s3_q));
    end
  end
  assign vbus_ok = pin_f_q[0];

  // Power-on reset fires only on the very first supply rise
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      supply_prev_q <= 1'b0;
      por_done_q <= 1'b0;
      por_q <= 1'b0;
    end else begin
      supply_prev_q <= |pin_f_q;
      por_q <= (|pin_f_q) & ~supply_prev_q & ~por_done_q; // R3
      if (|pin_f_q) begin
        por_done_q <= 1'b1;
      end
    end
  end

  // One-cycle soft reset pulse; it spares the serial slave so the write is acked
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      soft_q <= 1'b0;
    end else begin
      soft_q <= ~soft_q & wr_en & (reg_addr == REG_RESET) & wr_data[RESET_BIT]; // R4
    end
  end
  assign int_rst = rst | por_q | soft_q;

  // Stretch the pulse reset so the slow link domain is sure to see it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rst_cnt_q <= 6'(RST_STRETCH_CYC);
      rst_hold_q <= 1'b1;
    end else begin
      rst_hold_q <= rst_cnt_q != 6'h00;
      if (rst_cnt_q != 6'h00) begin
        rst_cnt_q <= rst_cnt_q - 6'h01;
      end
    end
  end

  // Link domain reset: first flop feeds only the second
  always_ff @(posedge adc_clk) begin
    arst_q <= {arst_q[0], rst_hold_q};
  end

  // Link domain: hold a sample until the reference side acknowledges it
  always_ff @(posedge adc_clk) begin
    ack_sy_q <= {ack_sy_q[1:0], req_f_q};
    if (arst_q[1]) begin
      ack_f_q <= 1'b0;
    end else if (ack_sy_q[1] == ack_sy_q[2]) begin
      ack_f_q <= ack_sy_q[2];
    end
  end

  // Samples arriving while a transfer is in flight are dropped, not queued
  always_ff @(posedge adc_clk) begin
    if (arst_q[1]) begin
      req_q <= 1'b0;
      hold_q <= '0;
    end else if (adc_sample && (req_q == ack_f_q)) begin
      hold_q <= adc_sense;
      req_q <= ~req_q;
    end
  end

  // Reference side of the toggle handshake; hold_q is stable while req differs
  always_ff @(posedge ref_clk) begin
    req_sy_q <= {req_sy_q[1:0], req_q};
    if (rst) begin
      req_f_q <= 1'b0;
      samp_q <= 1'b0;
      sense_q <= '0;
    end else begin
      samp_q <= 1'b0;
      if ((req_sy_q[1] == req_sy_q[2]) && (req_sy_q[2] != req_f_q)) begin
        req_f_q <= req_sy_q[2];
        sense_q <= hold_q;
        samp_q <= 1'b1;
      end
    end
  end

  // Code to accessory; window interpolation already happened in the converter
  function automatic acc_t classify(input sense_t s, input logic vb);
    acc_t a;
    a = ACC_UNKNOWN; // R10
    unique case (s.code)
      CODE_TA: a = vb ? ACC_TA : ACC_UNKNOWN; // R12
      CODE_FUSB_OFF: a = ACC_FUSB_OFF; // R13
      CODE_FUSB_ON: a = ACC_FUSB_ON; // R14
      CODE_FUART_OFF: a = ACC_FUART_OFF; // R15
      CODE_FUART_ON: a = ACC_FUART_ON; // R15
      CODE_OPEN: begin
        if (!vb) begin
          a = ACC_NONE; // R11
        end else if (s.dshort) begin
          a = ACC_DCP; // R19
        end else if (s.cdp) begin
          a = ACC_CDP; // R20
        end else begin
          a = ACC_SDP; // R20
        end
      end
      default: a = ACC_UNKNOWN;
    endcase
    return a;
  endfunction

  assign cls = classify(sense_q, vbus_ok); // R9
  assign change = samp_q & ((cls != acc_q) | (sense_q.code != code_q));

  // Detection result and standby state
  always_ff @(posedge ref_clk) begin
    if (int_rst) begin
      acc_q <= ACC_NONE;
      code_q <= CODE_OPEN;
      state_q <= ST_STANDBY; // R2
    end else if (change) begin
      acc_q <= cls; // R18
      code_q <= sense_q.code; // R10
      state_q <= (cls == ACC_NONE) ? ST_STANDBY : ST_ATTACHED;
    end
  end

  // Sticky attach and detach flags; a new event beats the read clear
  always_comb begin
    int_set = 2'b00;
    int_set[INT_ATTACH_BIT] = change & (cls != ACC_NONE);
    int_set[INT_DETACH_BIT] = change & (cls == ACC_NONE) & (acc_q != ACC_NONE);
  end
  always_ff @(posedge ref_clk) begin
    if (int_rst) begin
      int_q <= 2'b00;
    end else if (rd_en && reg_addr == REG_INT) begin
      int_q <= int_set; // R22
    end else begin
      int_q <= int_q | int_set; // R22
    end
  end

  // Pin follows the flags a cycle later, so status is readable first
  always_ff @(posedge ref_clk) begin
    if (int_rst) begin
      attach_irq_n <= 1'b1;
    end else begin
      attach_irq_n <= ~(|int_q) | ctrl_q[CTRL_MASK_BIT]; // R6 R18 R22
    end
  end

  // Writable configuration, byte wide
  always_ff @(posedge ref_clk) begin
    if (int_rst) begin
      ctrl_q <= CTRL_RESET; // R1
      man_q <= ZERO_BYTE;
    end else if (wr_en) begin
      if (reg_addr == REG_CTRL) begin
        ctrl_q <= wr_data; // R23
      end
      if (reg_addr == REG_MANUAL) begin
        man_q <= wr_data; // R7
      end
    end
  end

  // Read multiplexer; unmapped and write-only offsets read zero
  always_comb begin
    rd_data = ZERO_BYTE;
    unique case (reg_addr)
      REG_CTRL: rd_data = ctrl_q;
      REG_INT: rd_data = {6'h00, int_q};
      REG_ADC: rd_data = {3'h0, code_q}; // R10
      REG_MANUAL: rd_data = man_q;
      REG_TYPE1: begin
        unique case (acc_q)
          ACC_SDP: rd_data = T1_SDP;
          ACC_CDP: rd_data = T1_CDP;
          ACC_DCP: rd_data = T1_DCP;
          ACC_TA: rd_data = T1_TA;
          default: rd_data = ZERO_BYTE;
        endcase
      end
      REG_TYPE2: begin
        unique case (acc_q)
          ACC_FUSB_OFF: rd_data = T2_FUSB_OFF;
          ACC_FUSB_ON: rd_data = T2_FUSB_ON;
          ACC_FUART_OFF: rd_data = T2_FUART_OFF;
          ACC_FUART_ON: rd_data = T2_FUART_ON;
          ACC_UNKNOWN: rd_data = T2_UNKNOWN;
          default: rd_data = ZERO_BYTE;
        endcase
      end
      default: rd_data = ZERO_BYTE;
    endcase
  end

  // Auto routing follows the current result every cycle, no reattach needed; manual routing follows register 0x13
  always_ff @(posedge ref_clk) begin
    route_q <= '0; // R1
    if (!int_rst) begin
      if (!ctrl_q[CTRL_AUTO_BIT]) begin
        // Both bits set would short two host pairs, so that opens both
        if (man_q[MAN_USB_BIT] ^ man_q[MAN_ALT_BIT]) begin
          route_q.usb_en <= man_q[MAN_USB_BIT]; // R7
          route_q.alt_en <= man_q[MAN_ALT_BIT]; // R7
        end
      end else begin
        unique case (acc_q)
          ACC_FUSB_OFF, ACC_FUSB_ON, ACC_SDP, ACC_CDP: route_q.usb_en <= 1'b1; // R16 R17 R21
          ACC_FUART_OFF, ACC_FUART_ON: route_q.alt_en <= 1'b1; // R16 R17
          default: route_q <= '0; // R21
        endcase
      end
    end
  end
  assign sw_route = route_q;

  // Default charge current: high for chargers, low otherwise
  always_ff @(posedge ref_clk) begin
    if (int_rst) begin
      charge_high_current <= 1'b0;
    end else begin
      charge_high_current <= (acc_q == ACC_TA) | (acc_q == ACC_DCP) | (acc_q == ACC_CDP); // R8
    end
  end

  // Serial register port
  i2c_reg_slave #(
    .SLAVE_ADDR(SLAVE_ADDR)
  ) u_slave (
    .ref_clk(ref_clk),
    .rst(rst),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe(sda_oe), // R5
    .reg_addr(reg_addr),
    .wr_en(wr_en),
    .wr_data(wr_data),
    .rd_en(rd_en),
    .rd_data(rd_data)
  );

  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence s_change;
    change && !int_rst;
  endsequence
  sequence s_flag_then_pin;
    ##1 (int_q != 2'b00) ##1 (attach_irq_n == ctrl_q[CTRL_MASK_BIT]);
  endsequence

  AST_RESET_OPEN: assert property (int_rst |=> route_q == '0) else $error("switches not open after reset"); // R1
  AST_STANDBY: assert property (state_q == ST_STANDBY |-> acc_q == ACC_NONE) else $error("standby with accessory"); // R2
  AST_SOFT_RESET: assert property (wr_en && reg_addr == REG_RESET && wr_data[RESET_BIT] && !soft_q && !int_rst // R4
    |=> soft_q ##1 (ctrl_q == CTRL_RESET && acc_q == ACC_NONE)) else $error("soft reset lost");
  AST_MASKED: assert property (ctrl_q[CTRL_MASK_BIT] && $past(ctrl_q[CTRL_MASK_BIT]) |-> attach_irq_n) // R6
    else $error("interrupt while masked");
  AST_MANUAL: assert property (!ctrl_q[CTRL_AUTO_BIT] && !int_rst && man_q[1:0] == 2'b01 // R7
    |=> route_q.usb_en && !route_q.alt_en) else $error("manual route ignored");
  AST_TA_VBUS: assert property (change && !int_rst && sense_q.code == CODE_TA && !vbus_ok // R12
    |=> acc_q == ACC_UNKNOWN) else $error("charger code accepted without bus power");
  AST_UART_ROUTE: assert property (s_change ##0 (cls == ACC_FUART_ON && ctrl_q[CTRL_AUTO_BIT] && !soft_q) // R16
    ##1 !int_rst |=> route_q.alt_en && !route_q.usb_en) else $error("uart cable not routed");
  AST_IRQ_AFTER: assert property (s_change ##0 (cls != ACC_NONE) ##1 (!int_rst && !ctrl_q[CTRL_MASK_BIT]) // R18
    |=> !attach_irq_n) else $error("interrupt not raised after attach");
  AST_IRQ_ORDER: assert property (s_change ##0 (cls != ACC_NONE) // R18
    |-> s_flag_then_pin or ##1 int_rst or ##2 int_rst) else $error("interrupt pin did not follow flag");
  AST_DCP_OPEN: assert property (acc_q == ACC_DCP && ctrl_q[CTRL_AUTO_BIT] && !int_rst |=> route_q == '0) // R21
    else $error("dedicated charger routed");
  AST_SDP_LOW: assert property (acc_q == ACC_SDP && !int_rst |=> !charge_high_current) // R8
    else $error("standard port charged high");
endmodule

/* File: acc_det_ctrl_bench.sv */
// Bench for the accessory detect controller against a behavioural reference
`timescale 1ns/1ns
module acc_det_ctrl_bench import acc_det_pkg::*;;
  logic ref_clk = 1'b0;
  logic adc_clk = 1'b0;
  logic rst = 1'b1;
  logic adc_sample = 1'b0;
  sense_t adc_sense = {2'b00, CODE_OPEN};
  logic bus_power_in = 1'b0;
  logic bat_power_ok = 1'b0;
  logic scl_pin, sda_low, sda_o, sda_oe, attach_irq_n, charge_high_current;
  switch_t sw_route;
  // Open-drain data line with pull-up
  wire logic sda_line = ~(sda_low | (sda_oe & ~sda_o));
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  // Cases packed as {bus power, short, cdp, code}
  logic [7:0] tab [9] = '{8'h99, 8'h1C, 8'h9D, 8'h97, 8'h17, 8'hDF, 8'hBF, 8'h9F, 8'h1F};
  logic [4:0] unk [5] = '{5'h15, 5'h16, 5'h1A, 5'h1B, 5'h1E};

  always #4 ref_clk = ~ref_clk;
  // Link clock at 125 ns, offset so its edges drift against the reference
  initial begin
    #3;
    forever begin
      #62 adc_clk = ~adc_clk;
      #63 adc_clk = ~adc_clk;
    end
  end

  acc_det_ctrl #(.SLAVE_ADDR(SLAVE_ADDR_DEFAULT)) u_dut (.ref_clk(ref_clk), .rst(rst), .adc_clk(adc_clk),
    .adc_sample(adc_sample), .adc_sense(adc_sense), .bus_power_in(bus_power_in), .bat_power_ok(bat_power_ok),
    .scl_i(scl_pin), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .attach_irq_n(attach_irq_n),
    .sw_route(sw_route), .charge_high_current(charge_high_current));

  i2c_host_model u_host (.ref_clk(ref_clk), .sda_line(sda_line), .scl_pin(scl_pin), .sda_low(sda_low));

  // Reference result as {alt, usb, high current}
  function automatic int ref_out(input int code, input int vb, input int ds, input int cd);
    if (code == CODE_FUSB_OFF || code == CODE_FUSB_ON) return 2;
    if (code == CODE_FUART_OFF || code == CODE_FUART_ON) return 4;
    if (code == CODE_TA && vb) return 1;
    if (code == CODE_OPEN && vb) return ds ? 1 : (cd ? 3 : 2);
    return 0;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One conversion; the wait covers link sync plus classification
  task automatic sense(input logic vb, input logic [4:0] code, input logic ds, input logic cd);
    @(posedge ref_clk) bus_power_in <= vb;
    @(posedge adc_clk) begin
      adc_sense <= {ds, cd, code};
      adc_sample <= 1'b1;
    end
    @(posedge adc_clk) adc_sample <= 1'b0;
    repeat (200) @(posedge ref_clk);
  endtask

  task automatic wrap_up();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Cut a hang short at 90000 cycles, a little past the expected run length of about 76000 cycles
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      fails++;
      wrap_up();
    end
  end

  initial begin
    logic [7:0] d;
    logic [7:0] e;
    logic ok;
    void'($urandom(11));
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    bat_power_ok <= 1'b1;
    repeat (60) @(posedge ref_clk);
    chk({5'h0, sw_route, attach_irq_n}, 8'h01);
    u_host.wr(REG_CTRL, 8'h04, ok);
    chk({7'h0, ok}, 8'h01);
    $display("test defaults done");
    sense(1'b1, CODE_FUSB_OFF, 1'b0, 1'b0);
    chk({5'h0, sw_route, charge_high_current}, 8'(ref_out(CODE_FUSB_OFF, 1, 0, 0)));
    chk({7'h0, attach_irq_n}, 8'h00);
    u_host.rd(REG_INT, d);
    chk(d, 8'h01);
    repeat (20) @(posedge ref_clk);
    chk({7'h0, attach_irq_n}, 8'h01);
    $display("test first attach done");
    for (int i = 0; i < 10; i++) begin
      e = (i == 9) ? {1'($urandom), 2'b00, unk[$urandom % 5]} : tab[i];
      sense(e[7], e[4:0], e[6], e[5]);
      chk({5'h0, sw_route, charge_high_current}, 8'(ref_out(e[4:0], e[7], e[6], e[5])));
    end
    u_host.rd(REG_ADC, d);
    chk(d, {3'h0, e[4:0]});
    $display("test classification done");
    u_host.wr(REG_CTRL, 8'h00, ok);
    u_host.wr(REG_MANUAL, 8'h02, ok);
    repeat (20) @(posedge ref_clk);
    chk({5'h0, sw_route, attach_irq_n}, 8'h04);
    u_host.wr(REG_MANUAL, 8'h01, ok);
    repeat (20) @(posedge ref_clk);
    chk({5'h0, sw_route, attach_irq_n}, 8'h02);
    u_host.wr(REG_RESET, 8'h01, ok);
    repeat (20) @(posedge ref_clk);
    chk({5'h0, sw_route, attach_irq_n}, 8'h01);
    $display("test manual and soft reset done");
    wrap_up();
  end
endmodule

/* File: acc_det_pkg.sv */
// Shared constants and types for the accessory detect switch controller
package acc_det_pkg;
  // Register offsets
  localparam logic [7:0] REG_CTRL = 8'h02;
  localparam logic [7:0] REG_INT = 8'h03;
  localparam logic [7:0] REG_ADC = 8'h07;
  localparam logic [7:0] REG_TYPE1 = 8'h09;
  localparam logic [7:0] REG_TYPE2 = 8'h0A;
  localparam logic [7:0] REG_MANUAL = 8'h13;
  localparam logic [7:0] REG_RESET = 8'h1B;
  // Reset values and field positions
  localparam logic [7:0] CTRL_RESET = 8'h05;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam int CTRL_MASK_BIT = 0;
  localparam int CTRL_AUTO_BIT = 2;
  localparam int RESET_BIT = 0;
  localparam int MAN_USB_BIT = 0;
  localparam int MAN_ALT_BIT = 1;
  localparam int INT_ATTACH_BIT = 0;
  localparam int INT_DETACH_BIT = 1;
  // Device type register encodings
  localparam logic [7:0] T1_SDP = 8'h01;
  localparam logic [7:0] T1_CDP = 8'h02;
  localparam logic [7:0] T1_DCP = 8'h04;
  localparam logic [7:0] T1_TA = 8'h08;
  localparam logic [7:0] T2_FUSB_OFF = 8'h01;
  localparam logic [7:0] T2_FUSB_ON = 8'h02;
  localparam logic [7:0] T2_FUART_OFF = 8'h04;
  localparam logic [7:0] T2_FUART_ON = 8'h08;
  localparam logic [7:0] T2_UNKNOWN = 8'h10;
  // Resistance codes
  localparam logic [4:0] CODE_TA = 5'h17;
  localparam logic [4:0] CODE_FUSB_OFF = 5'h18;
  localparam logic [4:0] CODE_FUSB_ON = 5'h19;
  localparam logic [4:0] CODE_FUART_OFF = 5'h1C;
  localparam logic [4:0] CODE_FUART_ON = 5'h1D;
  localparam logic [4:0] CODE_OPEN = 5'h1F;
  // Serial slave
  localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h25; // Arbitrary value
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  // Timing: stretch reset so the slower link clock sees two edges
  localparam int REF_PERIOD_NS = 8;
  localparam int LINK_PERIOD_NS = 125;
  localparam int RST_STRETCH_CYC = (2 * LINK_PERIOD_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;

  typedef struct packed {
    logic dshort;
    logic cdp;
    logic [4:0] code;
  } sense_t;

  typedef struct packed {
    logic alt_en;
    logic usb_en;
  } switch_t;

  typedef enum logic [3:0] {
    ACC_NONE = 4'b0000,
    ACC_UNKNOWN = 4'b0001,
    ACC_TA = 4'b0010,
    ACC_FUSB_OFF = 4'b0011,
    ACC_FUSB_ON = 4'b0100,
    ACC_FUART_OFF = 4'b0101,
    ACC_FUART_ON = 4'b0110,
    ACC_DCP = 4'b0111,
    ACC_CDP = 4'b1000,
    ACC_SDP = 4'b1001
  } acc_t;

  typedef enum logic {
    ST_STANDBY = 1'b0,
    ST_ATTACHED = 1'b1
  } det_state_t;

  typedef enum logic [3:0] {
    I_IDLE = 4'b0000,
    I_ADDR = 4'b0001,
    I_AACK = 4'b0010,
    I_REG = 4'b0011,
    I_REG_ACK = 4'b0100,
    I_WDATA = 4'b0101,
    I_WACK = 4'b0110,
    I_RDATA = 4'b0111,
    I_RACK = 4'b1000
  } i2c_state_t;
endpackage

/* File: i2c_host_model.sv */
// Serial bus master model standing in for the host processor
`timescale 1ns/1ns
module i2c_host_model import acc_det_pkg::*; (
  input wire logic ref_clk,
  input wire logic sda_line,
  output logic scl_pin,
  output logic sda_low
);
  // Quarter bit of 672 ns keeps SCL near 372 kHz, inside fast mode
  localparam int QTR = 84;

  // Idle bus: SCL high, SDA released to its pull-up
  initial begin
    scl_pin = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tq();
    repeat (QTR) @(posedge ref_clk);
  endtask

  // Data moves a quarter after SCL falls, so it never races the fall
  task automatic bit_io(input logic b, output logic r);
    tq();
    sda_low <= ~b;
    tq();
    scl_pin <= 1'b1;
    tq();
    r = sda_line;
    tq();
    scl_pin <= 1'b0;
  endtask

  // One byte MSB first, then the acknowledge bit
  task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(mack, ack);
  endtask

  task automatic start();
    sda_low <= 1'b1;
    tq();
    scl_pin <= 1'b0;
  endtask

  task automatic stop();
    tq();
    sda_low <= 1'b1;
    tq();
    scl_pin <= 1'b1;
    tq();
    sda_low <= 1'b0;
    tq();
  endtask

  // Address, register, one data byte; ok high when all three acked
  task automatic wr(input logic [7:0] ra, input logic [7:0] wd, output logic ok);
    logic [7:0] rx;
    logic a0, a1, a2;
    start();
    xfer({SLAVE_ADDR_DEFAULT, 1'b0}, 1'b1, rx, a0);
    xfer(ra, 1'b1, rx, a1);
    xfer(wd, 1'b1, rx, a2);
    stop();
    ok = ~(a0 | a1 | a2);
  endtask

  // Pointer write, repeated start, one byte read closed by a not-acknowledge
  task automatic rd(input logic [7:0] ra, output logic [7:0] rdata);
    logic [7:0] rx;
    logic a;
    start();
    xfer({SLAVE_ADDR_DEFAULT, 1'b0}, 1'b1, rx, a);
    xfer(ra, 1'b1, rx, a);
    tq();
    sda_low <= 1'b0;
    tq();
    scl_pin <= 1'b1;
    tq();
    start();
    xfer({SLAVE_ADDR_DEFAULT, 1'b1}, 1'b1, rx, a);
    xfer(8'hFF, 1'b1, rdata, a);
    stop();
  endtask
endmodule

/* File: i2c_reg_slave.sv */
// Byte-wide serial register slave, oversampled on the reference clock
`timescale 1ns/1ns
module i2c_reg_slave import acc_det_pkg::*; #(
  parameter logic [6:0] SLAVE_ADDR = SLAVE_ADDR_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic [7:0] reg_addr,
  output logic wr_en,
  output logic [7:0] wr_data,
  output logic rd_en,
  input wire logic [7:0] rd_data
);
  logic [1:0] s1_q, s2_q, s3_q, f_q, p_q;
  logic scl_rise, scl_fall, start, stop;
  i2c_state_t st_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q, tx_q, ptr_q;
  logic rw_q, drv_q;

  // Three stage sync; a level counts once stages two and three agree
  always_ff @(posedge ref_clk) begin
    s1_q <= {scl_i, sda_i};
    s2_q <= s1_q;
    s3_q <= s2_q;
    if (rst) begin
      f_q <= 2'b11;
      p_q <= 2'b11;
    end else begin
      f_q <= (s3_q & ~(s2_q ^ s3_q)) | (f_q & (s2_q ^ s3_q));
      p_q <= f_q;
    end
  end

  assign scl_rise = f_q[1] & ~p_q[1];
  assign scl_fall = ~f_q[1] & p_q[1];
  assign start = f_q[1] & p_q[1] & p_q[0] & ~f_q[0];
  assign stop = f_q[1] & p_q[1] & ~p_q[0] & f_q[0];

  // Strobes are combinational so the address is still the one addressed
  assign wr_en = scl_fall & ~start & ~stop & (st_q == I_WDATA) & (cnt_q == BITS_PER_BYTE);
  assign rd_en = scl_fall & ~start & ~stop & (((st_q == I_AACK) & rw_q) | (st_q == I_RACK));
  assign wr_data = sh_q;
  assign reg_addr = ptr_q;
  assign sda_o = 1'b0;
  assign sda_oe = drv_q;

  // Protocol sequencer; sample on SCL rise, change SDA on SCL fall
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q <= I_IDLE;
      cnt_q <= '0;
      sh_q <= ZERO_BYTE;
      tx_q <= ZERO_BYTE;
      ptr_q <= ZERO_BYTE;
      rw_q <= 1'b0;
      drv_q <= 1'b0;
    end else if (stop) begin
      st_q <= I_IDLE;
      drv_q <= 1'b0;
    end else if (start) begin
      st_q <= I_ADDR;
      cnt_q <= '0;
      drv_q <= 1'b0;
    end else if (scl_rise) begin
      if (st_q == I_ADDR || st_q == I_REG || st_q == I_WDATA) begin
        sh_q <= {sh_q[6:0], f_q[0]};
        cnt_q <= cnt_q + 4'h1;
      end
      if (st_q == I_RACK && f_q[0]) begin
        st_q <= I_IDLE; // Master refused more data
      end
    end else if (scl_fall) begin
      unique case (st_q)
        I_IDLE: begin
        end
        I_ADDR: begin
          if (cnt_q == BITS_PER_BYTE) begin
            if (sh_q[7:1] == SLAVE_ADDR) begin
              st_q <= I_AACK;
              rw_q <= sh_q[0];
              drv_q <= 1'b1;
            end else begin
              st_q <= I_IDLE;
            end
          end
        end
        I_AACK: begin
          cnt_q <= '0;
          if (rw_q) begin
            st_q <= I_RDATA;
            tx_q <= rd_data;
            ptr_q <= ptr_q + 8'h01;
            drv_q <= ~rd_data[7];
          end else begin
            st_q <= I_REG;
            drv_q <= 1'b0;
          end
        end
        I_REG: begin
          if (cnt_q == BITS_PER_BYTE) begin
            ptr_q <= sh_q;
            st_q <= I_REG_ACK;
            drv_q <= 1'b1;
          end
        end
        I_REG_ACK, I_WACK: begin
          st_q <= I_WDATA;
          drv_q <= 1'b0;
          cnt_q <= '0;
        end
        I_WDATA: begin
          if (cnt_q == BITS_PER_BYTE) begin
            ptr_q <= ptr_q + 8'h01;
            st_q <= I_WACK;
            drv_q <= 1'b1;
          end
        end
        I_RDATA: begin
          if (cnt_q == LAST_BIT) begin
            st_q <= I_RACK;
            drv_q <= 1'b0;
          end else begin
            cnt_q <= cnt_q + 4'h1;
            tx_q <= {tx_q[6:0], 1'b0};
            drv_q <= ~tx_q[6];
          end
        end
        I_RACK: begin
          st_q <= I_RDATA;
          tx_q <= rd_data;
          ptr_q <= ptr_q + 8'h01;
          drv_q <= ~rd_data[7];
          cnt_q <= '0;
        end
        default: begin
          st_q <= I_IDLE;
          drv_q <= 1'b0;
        end
      endcase
    end
  end
endmodule
